/* led_sink_serial_config_bench.sv */
`timescale 1ns/1ps
module led_sink_serial_config_bench;
  // ----------------------------------------------------------------
  // signals, instances, tasks
  // ----------------------------------------------------------------
  logic             clk = 1'b0;
  logic             rst_n = 1'b0;
  logic [7:0]       addr = 8'h00;
  logic [31:0]      wdata = 32'h0;
  logic             wr = 1'b0;
  logic             rd = 1'b0;
  logic             rd_d = 1'b0;
  logic [31:0]      rdata;
  logic             irq;
  logic [15:0]      open_led = 16'h0000;
  logic             overtemp = 1'b0;
  logic [15:0]      ch_on;
  logic [15:0][7:0] ch_level;
  logic [31:0]      seed = 32'h7e55;
  logic [31:0]      exp_q[$];
  logic [6:0]       code[16];
  logic [15:0]      v;
  int               failures = 0;
  int               samples_checked = 0;
  lsc_if lnk ();
  lsc_device i_lsc_device (.clk(clk), .rst_n(rst_n), .lnk(lnk.dev), .open_led_flag(open_led),
    .overtemp_flag(overtemp), .ch_on(ch_on), .ch_level(ch_level));
  lsc_ctrl i_lsc_ctrl (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .lnk(lnk.ctl));
  lsc_assertions i_lsc_assertions (.clk(clk), .rst_n(rst_n), .sclk(lnk.sclk),
    .ser_in(lnk.ser_in), .mode(lnk.mode), .latch_strobe(lnk.latch_strobe),
    .fault_n_od_o(lnk.fault_n_od_o), .fault_n_od_oe(lnk.fault_n_od_oe));
  always #4 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction : xs
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(d);
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg
  task automatic go(input logic [31:0] c);
    int n;
    wr_reg(lsc_pkg::A_CTRL, c);
    for (n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge clk);
    if (n == 3000) failures++;
    repeat (10) @(posedge clk);
  endtask : go
  task automatic chk_codes();
    for (int n = 0; n < 16; n++) check(32'(ch_level[n]), 32'(code[n]));
  endtask : chk_codes
  task automatic final_report();
    $display("compared %0d mismatched %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk) if (rd_d) check(rdata, exp_q.pop_front());
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    final_report();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    check(32'(lnk.blank), 32'h1);
    rd_reg(lsc_pkg::A_STATUS, 32'h0);
    rd_reg(8'hfc, 32'h0);
    wr_reg(lsc_pkg::A_IRQ_MSK, 32'h3);
    $display("test reset done");
    seed = xs(seed);
    v = seed[15:0];
    wr_reg(lsc_pkg::A_ONOFF, 32'(v));
    go(32'h1);
    check(32'(ch_on), 32'(v));
    check(32'(lnk.ser_out), 32'(v[15]));
    rd_reg(lsc_pkg::A_IRQ_ST, 32'h1);
    wr_reg(lsc_pkg::A_IRQ_ST, 32'h1);
    rd_reg(lsc_pkg::A_IRQ_ST, 32'h0);
    check(32'(irq), 32'h0);
    $display("test onoff done");
    for (int n = 0; n < 16; n++) begin
      seed = xs(seed);
      code[n] = (n == 15) ? 7'(lsc_pkg::CODE_MAX) : (n == 0) ? 7'h00 : seed[6:0];
      wr_reg(8'(lsc_pkg::A_BC0 + 4 * n), 32'(code[n]));
    end
    go(32'h3);
    chk_codes();
    check(32'(lnk.ser_out), 32'(code[15][6]));
    wr_reg(lsc_pkg::A_IRQ_ST, 32'h1);
    wr_reg(lsc_pkg::A_ONOFF, 32'(~v));
    go(32'h1);
    chk_codes();
    check(32'(ch_on), {16'h0000, ~v});
    $display("test codes done");
    wr_reg(lsc_pkg::A_CTRL, 32'h4);
    repeat (10) @(posedge clk);
    check(32'(ch_on), 32'h0);
    wr_reg(lsc_pkg::A_CTRL, 32'h0);
    repeat (10) @(posedge clk);
    check(32'(ch_on), {16'h0000, ~v});
    $display("test blank done");
    wr_reg(lsc_pkg::A_IRQ_ST, 32'h3);
    wr_reg(lsc_pkg::A_IRQ_MSK, 32'h0);
    seed = xs(seed);
    v = seed[15:0] | 16'h0001;
    wr_reg(lsc_pkg::A_ONOFF, 32'(v));
    wr_reg(lsc_pkg::A_CTRL, 32'h1);
    repeat (200) @(posedge clk);
    check(32'(ch_on), 32'(v));
    check(32'(irq), 32'h0);
    rd_reg(lsc_pkg::A_IRQ_ST, 32'h1);
    wr_reg(lsc_pkg::A_IRQ_ST, 32'h1);
    wr_reg(lsc_pkg::A_IRQ_MSK, 32'h3);
    $display("test mask done");
    overtemp <= 1'b1;
    repeat (10) @(posedge clk);
    check(32'(lnk.fault_n), 32'h0);
    rd_reg(lsc_pkg::A_STATUS, 32'h2);
    check(32'(irq), 32'h1);
    overtemp <= 1'b0;
    repeat (10) @(posedge clk);
    check(32'(lnk.fault_n), 32'h1);
    open_led <= v;
    repeat (10) @(posedge clk);
    check(32'(lnk.fault_n), 32'h0);
    wr_reg(lsc_pkg::A_CTRL, 32'h4);
    repeat (10) @(posedge clk);
    check(32'(lnk.fault_n), 32'h1);
    $display("test fault done");
    final_report();
  end
endmodule : led_sink_serial_config_bench

/* lsc_assertions.sv */
`timescale 1ns/1ps
module lsc_assertions (
  // system
  input wire logic clk,
  input wire logic rst_n,
  // link
  input wire logic sclk,
  input wire logic ser_in,
  input wire logic mode,
  input wire logic latch_strobe,
  input wire logic fault_n_od_o,
  input wire logic fault_n_od_oe
);
  // ----------------------------------------------------------------
  // bit counter and properties
  // ----------------------------------------------------------------
  logic       sclk_q;
  logic [7:0] bits_reg;
  wire        rise = sclk & ~sclk_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) sclk_q <= 1'b0;
    else sclk_q <= sclk;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) bits_reg <= 8'h00;
    else if (latch_strobe) bits_reg <= 8'h00;
    else if (rise) bits_reg <= bits_reg + 8'h01;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_pulse; latch_strobe [*4] ##1 !latch_strobe; endsequence
  sequence s_high; sclk [*4] ##1 !sclk; endsequence
  AST_BITS: assert property ($rose(latch_strobe) |->
    bits_reg == (mode ? 8'h70 : 8'h10)) else $error("bit count");
  AST_PULSE: assert property ($rose(latch_strobe) |-> s_pulse) else $error("pulse");
  AST_SCLK_IDLE: assert property ($rose(latch_strobe) |-> !sclk) else $error("sclk");
  AST_QUIET: assert property (latch_strobe && $past(latch_strobe) |->
    $stable(sclk) && $stable(ser_in)) else $error("moved in latch");
  AST_HIGH: assert property ($rose(sclk) |-> s_high) else $error("high half");
  AST_LOW: assert property ($fell(sclk) |-> !sclk [*4]) else $error("low half");
  AST_MODE: assert property ($rose(sclk) |-> $stable(mode)) else $error("mode");
  AST_MODE_LAT: assert property (latch_strobe |-> $stable(mode)) else $error("mode");
  AST_FAULT: assert property (fault_n_od_oe |-> !fault_n_od_o) else $error("fault");
endmodule : lsc_assertions

/* lsc_ctrl.sv */
`timescale 1ns/1ps
module lsc_ctrl (
  // system
  input  wire logic        clk,
  input  wire logic        rst_n,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata,
  output logic             irq,
  // link
  lsc_if.ctl               lnk
);
  typedef enum logic [3:0] {
    S_IDLE  = 4'b0001,
    S_LOW   = 4'b0010,
    S_HIGH  = 4'b0100,
    S_LATCH = 4'b1000
  } lsc_state_e;
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  lsc_state_e st_reg;
  logic [2:0]   ctrl_reg;
  logic [15:0]  oo_reg;
  logic [111:0] bc_reg;
  logic [111:0] sh_reg;
  logic [6:0]   cnt_reg;
  logic [3:0]   div_reg;
  logic [1:0]   ist_reg;
  logic [1:0]   msk_reg;
  logic         f1_reg;
  logic         f2_reg;
  wire fault = ~f2_reg;
  wire busy  = (st_reg != S_IDLE);
  wire go    = wr && addr == lsc_pkg::A_CTRL && wdata[lsc_pkg::CTRL_GO] && !busy;
  wire tick  = (div_reg == lsc_pkg::HALF_CNT);
  wire done  = (st_reg == S_LATCH) && tick;
  wire [7:0] boff   = addr - lsc_pkg::A_BC0;
  wire [3:0] bidx   = boff[5:2];
  wire       bc_hit = boff[7:6] == 2'b00 && boff[1:0] == 2'b00;
  wire [6:0] nbits  = wdata[lsc_pkg::CTRL_MODE] ? 7'(lsc_pkg::BC_BITS - 1)
                                                : 7'(lsc_pkg::OO_BITS - 1);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) f1_reg <= 1'b1;
    else f1_reg <= lnk.fault_n;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) f2_reg <= 1'b1;
    else f2_reg <= f1_reg;
  end
  // ----------------------------------------------------------------
  // software writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= lsc_pkg::RST_CTRL;
      oo_reg   <= 16'h0000;
      bc_reg   <= '0;
      msk_reg  <= 2'h0;
      ist_reg  <= 2'h0;
    end else begin
      if (wr && addr == lsc_pkg::A_CTRL && !busy) ctrl_reg <= wdata[2:0];
      if (wr && addr == lsc_pkg::A_ONOFF) oo_reg <= wdata[15:0];
      if (wr && bc_hit) bc_reg[bidx*7 +: 7] <= wdata[6:0];
      if (wr && addr == lsc_pkg::A_IRQ_MSK) msk_reg <= wdata[1:0];
      ist_reg <= (ist_reg & ~((wr && addr == lsc_pkg::A_IRQ_ST) ? wdata[1:0] : 2'h0))
                 | {fault, done};
    end
  end
  // ----------------------------------------------------------------
  // link sequencer: shift whole packet, then strobe pulse
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg  <= S_IDLE;
      sh_reg  <= '0;
      cnt_reg <= 7'h00;
      div_reg <= 4'h0;
      lnk.sclk <= 1'b0;
      lnk.ser_in <= 1'b0;
      lnk.latch_strobe <= 1'b0;
      lnk.mode <= 1'b0;
      lnk.blank <= 1'b1;
    end else begin
      div_reg <= (busy && !tick) ? div_reg + 4'h1 : 4'h0;
      lnk.blank <= ctrl_reg[lsc_pkg::CTRL_BLANK];
      case (st_reg)
        S_IDLE: if (go) begin
          lnk.mode <= wdata[lsc_pkg::CTRL_MODE];
          sh_reg   <= wdata[lsc_pkg::CTRL_MODE] ? bc_reg : {oo_reg, 96'h0};
          cnt_reg  <= nbits;
          st_reg   <= S_LOW;
        end
        S_LOW: if (tick) begin
          lnk.ser_in <= sh_reg[111];
          lnk.sclk   <= 1'b1;
          st_reg     <= S_HIGH;
        end else lnk.sclk <= 1'b0;
        S_HIGH: if (tick) begin
          lnk.sclk <= 1'b0;
          sh_reg   <= {sh_reg[110:0], 1'b0};
          cnt_reg  <= cnt_reg - 7'h01;
          st_reg   <= (cnt_reg == 7'h00) ? S_LATCH : S_LOW;
          lnk.latch_strobe <= (cnt_reg == 7'h00);
        end
        S_LATCH: if (tick) begin
          lnk.latch_strobe <= 1'b0;
          st_reg <= S_IDLE;
        end
        default: st_reg <= S_IDLE;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // read port and interrupt
  // ----------------------------------------------------------------
  wire [31:0] rmux =
    addr == lsc_pkg::A_CTRL    ? {29'h0, ctrl_reg} :
    addr == lsc_pkg::A_STATUS  ? {30'h0, fault, busy} :
    addr == lsc_pkg::A_IRQ_ST  ? {30'h0, ist_reg} :
    addr == lsc_pkg::A_IRQ_MSK ? {30'h0, msk_reg} :
    addr == lsc_pkg::A_ONOFF   ? {16'h0, oo_reg} :
    bc_hit                     ? {25'h0, bc_reg[bidx*7 +: 7]} : 32'h0;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h0;
      irq   <= 1'b0;
    end else begin
      rdata <= rd ? rmux : 32'h0;
      irq   <= |(ist_reg & msk_reg);
    end
  end
endmodule : lsc_ctrl

/* lsc_device.sv */
`timescale 1ns/1ps
// Summary of operation
// - sclk rise shifts mode-selected register
// - mode low: 16-bit, latch on strobe rise
// - mode high: 112-bit, transparent while strobe high
// - strobe low holds correction codes
// - controller keeps sclk, data still while strobe high
// - controller shifts packet, then pulses strobe
// - sixteen 7-bit codes, msb first
// - code scales current, 0..127 of full scale
// - 16 on/off flags, msb first
// - each channel switched on its own
// - blank high disables all outputs
// - latch needs no blanking
// - fault pulls open-drain error low
// - shift register end drives ser_out
// - controller loads both sets after power-up; here only a software GO write to A_CTRL loads, one set per write
module lsc_device (
  // system
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // link
  lsc_if.dev                        lnk,
  // analog-side status
  input  wire logic [15:0]          open_led_flag,
  input  wire logic                 overtemp_flag,
  // channel drive
  output logic [15:0]               ch_on,
  output logic [15:0][7:0]          ch_level
);
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [4:0]  s1_reg;
  logic [4:0]  s2_reg;
  logic [4:0]  s3_reg;
  logic [16:0] e1_reg;
  logic [16:0] e2_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 5'h00;
      s2_reg <= 5'h00;
      s3_reg <= 5'h00;
    end else begin
      s1_reg <= {lnk.sclk, lnk.ser_in, lnk.mode, lnk.latch_strobe, lnk.blank};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  wire sclk_rise = s2_reg[4] & ~s3_reg[4];
  wire din       = s2_reg[3];
  wire mode      = s2_reg[2];
  wire lat       = s2_reg[1];
  wire lat_rise  = s2_reg[1] & ~s3_reg[1];
  wire blank     = s2_reg[0];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      e1_reg <= 17'h00000;
      e2_reg <= 17'h00000;
    end else begin
      e1_reg <= {overtemp_flag, open_led_flag};
      e2_reg <= e1_reg;
    end
  end
  wire        ot_sync = e2_reg[16];
  wire [15:0] ol_sync = e2_reg[15:0];
  // ----------------------------------------------------------------
  // strobe decode
  // ----------------------------------------------------------------
  wire bsr_shift = sclk_rise & mode;
  wire osr_shift = sclk_rise & ~mode;
  wire bc_load   = mode & lat;
  wire oo_load   = ~mode & lat_rise;
  // ----------------------------------------------------------------
  // shift registers and latches
  // ----------------------------------------------------------------
  logic [lsc_pkg::BC_BITS-1:0] bsr_reg;
  logic [lsc_pkg::OO_BITS-1:0] osr_reg;
  logic [lsc_pkg::BC_BITS-1:0] bc_reg;
  logic [lsc_pkg::OO_BITS-1:0] oo_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)         bsr_reg <= '0;
    else if (bsr_shift) bsr_reg <= {bsr_reg[lsc_pkg::BC_BITS-2:0], din};
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)         osr_reg <= '0;
    else if (osr_shift) osr_reg <= {osr_reg[lsc_pkg::OO_BITS-2:0], din};
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)       bc_reg <= '0;
    else if (bc_load) bc_reg <= bsr_reg;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)       oo_reg <= '0;
    else if (oo_load) oo_reg <= osr_reg;
  end
  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  wire        fault   = ot_sync | (|(ol_sync & oo_reg) & ~blank);
  wire [15:0] on_next = blank ? 16'h0000 : oo_reg;
  wire        so_next = mode ? bsr_reg[lsc_pkg::BC_BITS-1]
                             : osr_reg[lsc_pkg::OO_BITS-1];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ch_on <= 16'h0000;
    else        ch_on <= on_next;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) lnk.ser_out <= 1'b0;
    else        lnk.ser_out <= so_next;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) lnk.fault_n_od_oe <= 1'b0;
    else        lnk.fault_n_od_oe <= fault;
  end
  assign lnk.fault_n_od_o = 1'b0;
  genvar g;
  generate
    for (g = 0; g < lsc_pkg::CHANNELS; g++) begin : g_ch
      // channel 0 code sits in the low bits: bit 6 of ch15 shifted first
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) ch_level[g] <= 8'h00;
        else        ch_level[g] <= {1'b0, bc_reg[g*lsc_pkg::CODE_W +: lsc_pkg::CODE_W]};
      end
    end
  endgenerate
endmodule : lsc_device

/* lsc_if.sv */
`timescale 1ns/1ps
interface lsc_if;
  logic sclk;
  logic ser_in;
  logic mode;
  logic latch_strobe;
  logic blank;
  logic ser_out;
  logic fault_n_od_o;
  logic fault_n_od_oe;
  wire  fault_n = fault_n_od_oe ? fault_n_od_o : 1'b1;
  modport dev (input sclk, ser_in, mode, latch_strobe, blank, output ser_out,
               fault_n_od_o, fault_n_od_oe);
  modport ctl (output sclk, ser_in, mode, latch_strobe, blank, input ser_out, fault_n);
endinterface : lsc_if

/* lsc_pkg.sv */
package lsc_pkg;
  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int CHANNELS   = 16;
  localparam int CODE_W     = 7;
  localparam int BC_BITS    = 112;
  localparam int OO_BITS    = 16;
  localparam int CODE_MAX   = 127;
  // ----------------------------------------------------------------
  // controller register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_STATUS  = 8'h04;
  localparam logic [7:0] A_IRQ_ST  = 8'h08;
  localparam logic [7:0] A_IRQ_MSK = 8'h0c;
  localparam logic [7:0] A_ONOFF   = 8'h10;
  localparam logic [7:0] A_BC0     = 8'h20;
  // ctrl bits
  localparam int CTRL_GO    = 0;
  localparam int CTRL_MODE  = 1;
  localparam int CTRL_BLANK = 2;
  // status / irq bits
  localparam int ST_BUSY    = 0;
  localparam int ST_FAULT   = 1;
  localparam int IRQ_DONE   = 0;
  localparam int IRQ_FAULT  = 1;
  // ----------------------------------------------------------------
  // timing: link clock half period in system cycles
  // ----------------------------------------------------------------
  localparam int CLK_NS     = 8;
  localparam int HALF_NS    = 32;
  localparam int HALF_CYC   = (HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] HALF_CNT = 4'(HALF_CYC - 1);
  localparam logic [2:0] RST_CTRL = 3'h0;
endpackage : lsc_pkg
